// file: inc/pmd_consts.vh
/*
 * Constants for the phase-matched clock divider: default insertion delay,
 * reset-release clock selections and reset values.
 * Assumes inclusion by bare name from files under logic/.
 */
`ifndef PMD_CONSTS_VH
`define PMD_CONSTS_VH

// Default insertion delay, in mclk_in cycles, inside the delay line
`define PMD_DELAY_STAGES 2

// Reset-release clock select encodings
`define PMD_SEL_PRIMARY 2'h0
`define PMD_SEL_COMP_B 2'h1
`define PMD_SEL_COMP_C 2'h2
`define PMD_SEL_COMP_D 2'h3

// Release gate enable settings
`define PMD_GATE_OFF 1'h0
`define PMD_GATE_ON 1'h1

// Reset values
`define PMD_RST_PHASE 3'h0
`define PMD_RST_CLOCKS 4'h0

`endif

// file: logic/pmd_delay_line.v
/*
 * Equal-depth shift register delaying a bundle of sampled clock levels.
 * Assumes inputs synchronous to clk_in; rst_in is synchronous, active high.
 */
module pmd_delay_line #(
    parameter WIDTH = 4,
    parameter DEPTH = 2
) (
    input wire clk_in,              // sampling clock
    input wire rst_in,              // synchronous reset
    input wire [WIDTH-1:0] d_in,    // levels to delay
    output wire [WIDTH-1:0] q_out   // levels delayed DEPTH cycles
);
    reg [WIDTH-1:0] stage [0:DEPTH-1];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : tap
            always @(posedge clk_in) begin
                if (rst_in) begin
                    stage[g] <= {WIDTH{1'b0}};
                end else if (g == 0) begin
                    stage[g] <= d_in;
                end else begin
                    stage[g] <= stage[(g > 0) ? g - 1 : 0];
                end
            end
        end
    endgenerate

    assign q_out = stage[DEPTH-1];
endmodule

// file: logic/pmd_divider.v
/*
 * Phase-matched divider: delayed copies of four clocks and divide by 2,
 * 4 and 8 of the primary clock, rising-edge aligned to its delayed copy.
 * Assumes all clock inputs are slow levels sampled by mclk_in (at least
 * two mclk_in cycles per high and low phase); rst_in synchronous high.
 */
// How it works
// - Primary makes a delayed copy plus half, quarter, eighth rate outputs.
// - Delayed primary and divided outputs rise on the same cycle.
// - All four clocks pass one identical delay line.
// - Companion clocks come out undivided at original frequency.
// - Reset forces every output low at once, no edge awaited.
// - Reset removal is registered on a clock edge before outputs run.
// - Release strobe starts the divided outputs in step with the primary.
// - Parameter picks which input clock registers reset removal.
// - Parameter, default off, makes divided outputs wait for release.
// - Divided outputs are 50/50; delayed outputs keep input duty.
// - Gate off: each output starts at its own clock's next rise once lanes arm.
// - Gate on: strobe rise starts dividers at next primary rise.
// - Strobe is edge sensitive, only out of reset, accepted once.
`include "pmd_consts.vh"

module pmd_divider #(
    parameter DELAY_STAGES = `PMD_DELAY_STAGES,
    parameter [1:0] RESET_RELEASE_SEL = `PMD_SEL_PRIMARY,
    parameter [0:0] RELEASE_GATE_ENABLE = `PMD_GATE_OFF
) (
    input wire mclk_in,                 // sampling clock
    input wire rst_in,                  // synchronous reset, high
    input wire primary_clock_in,        // divided clock source
    input wire companion_clock_in_b,    // companion clock b
    input wire companion_clock_in_c,    // companion clock c
    input wire companion_clock_in_d,    // companion clock d
    input wire release_strobe_in,       // divided-output release
    output wire primary_delayed_out,    // delayed primary
    output wire half_rate_out,          // primary / 2
    output wire quarter_rate_out,       // primary / 4
    output wire eighth_rate_out,        // primary / 8
    output wire companion_delayed_out_b, // delayed companion b
    output wire companion_delayed_out_c, // delayed companion c
    output wire companion_delayed_out_d  // delayed companion d
);
    // Arming steps after reset removal
    localparam [1:0] ST_WAIT_RISE = 2'h0;
    localparam [1:0] ST_WAIT_FALL = 2'h1;
    localparam [1:0] ST_ARMED = 2'h2;

    function [3:0] pmd_sel_hot;
        input [1:0] sel;
        begin
            case (sel)
                `PMD_SEL_PRIMARY: pmd_sel_hot = 4'h1;
                `PMD_SEL_COMP_B: pmd_sel_hot = 4'h2;
                `PMD_SEL_COMP_C: pmd_sel_hot = 4'h4;
                default: pmd_sel_hot = 4'h8;
            endcase
        end
    endfunction

    wire [3:0] raw_clk;
    wire [3:0] dly;
    wire [3:0] rise;
    wire [3:0] fall;
    wire [3:0] sel_hot;
    wire sel_rise;
    wire sel_fall;
    wire prim_rise;
    wire start_ok;
    wire strobe_edge;
    wire run_del;

    reg [3:0] prev;
    reg [3:0] chan_en;
    reg [3:0] clk_q;
    reg [1:0] arm_state;
    reg [1:0] next_arm;
    reg div_run;
    reg [2:0] phase;
    reg rel_prev;
    reg rel_ok;
    reg [2:0] div_q;
    reg next_run;
    reg [2:0] next_phase;

    assign raw_clk = {companion_clock_in_d, companion_clock_in_c,
                      companion_clock_in_b, primary_clock_in};

    // Same depth for every lane keeps input skews intact
    pmd_delay_line #(
        .WIDTH(4),
        .DEPTH(DELAY_STAGES)
    ) u_delay (
        .clk_in(mclk_in),
        .rst_in(rst_in),
        .d_in(raw_clk),
        .q_out(dly)
    );

    assign rise = dly & ~prev;
    assign fall = ~dly & prev;
    assign sel_hot = pmd_sel_hot(RESET_RELEASE_SEL);
    assign sel_rise = |(rise & sel_hot);
    assign sel_fall = |(fall & sel_hot);
    assign prim_rise = rise[0] & chan_en[0];

    // Gate off: dividers follow the primary lane as soon as it runs
    assign start_ok = (RELEASE_GATE_ENABLE == `PMD_GATE_ON) ?
                      rel_ok : 1'b1;
    assign strobe_edge = release_strobe_in & ~rel_prev;

    // Removal is registered on a rise, lanes armed at the next fall
    always @(posedge mclk_in) begin
        if (rst_in) begin
            prev <= `PMD_RST_CLOCKS;
            arm_state <= ST_WAIT_RISE;
        end else begin
            prev <= dly;
            arm_state <= next_arm;
        end
    end

    // Latency of one selected-clock cycle is traded for whole first pulses
    always @* begin
        next_arm = arm_state;
        case (arm_state)
            ST_WAIT_RISE: begin
                if (sel_rise) begin
                    next_arm = ST_WAIT_FALL;
                end
            end
            ST_WAIT_FALL: begin
                if (sel_fall) begin
                    next_arm = ST_ARMED;
                end
            end
            ST_ARMED: begin
                next_arm = ST_ARMED;
            end
            default: begin
                next_arm = ST_WAIT_RISE;
            end
        endcase
    end

    assign run_del = (arm_state == ST_ARMED);

    // Each lane starts only while low, so no first pulse is truncated
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : lane
            always @(posedge mclk_in) begin
                if (rst_in) begin
                    chan_en[g] <= 1'b0;
                    clk_q[g] <= 1'b0;
                end else begin
                    if (run_del && !dly[g]) begin
                        chan_en[g] <= 1'b1;
                    end
                    clk_q[g] <= dly[g] & chan_en[g];
                end
            end
        end
    endgenerate

    // Strobe taken once per reset; later edges are ignored
    always @(posedge mclk_in) begin
        // History follows the pin in reset: a strobe held high is no edge
        rel_prev <= release_strobe_in;
        if (rst_in) begin
            rel_ok <= 1'b0;
        end else begin
            if (strobe_edge && !rel_ok) begin
                rel_ok <= 1'b1;
            end
        end
    end

    always @* begin
        next_run = div_run;
        next_phase = phase;
        if (prim_rise) begin
            if (div_run) begin
                next_phase = phase + 3'h1;
            end else if (start_ok) begin
                next_run = 1'b1;
                next_phase = `PMD_RST_PHASE;
            end
        end
    end

    always @(posedge mclk_in) begin
        if (rst_in) begin
            div_run <= 1'b0;
            phase <= `PMD_RST_PHASE;
        end else begin
            div_run <= next_run;
            phase <= next_phase;
        end
    end

    // Divided levels change only on primary rises: 50/50 by construction
    generate
        for (g = 0; g < 3; g = g + 1) begin : ratio
            always @(posedge mclk_in) begin
                if (rst_in) begin
                    div_q[g] <= 1'b0;
                end else begin
                    // Bit g of the phase halves the rate once more
                    div_q[g] <= next_run & ~next_phase[g];
                end
            end
        end
    endgenerate

    // Reset gates outputs combinationally so they drop without an edge
    assign primary_delayed_out = clk_q[0] & ~rst_in;
    assign companion_delayed_out_b = clk_q[1] & ~rst_in;
    assign companion_delayed_out_c = clk_q[2] & ~rst_in;
    assign companion_delayed_out_d = clk_q[3] & ~rst_in;
    assign half_rate_out = div_q[0] & ~rst_in;
    assign quarter_rate_out = div_q[1] & ~rst_in;
    assign eighth_rate_out = div_q[2] & ~rst_in;
endmodule

// file: sim/pmd_clk_src.sv
/* Upstream clock sources: four slow clocks of one period, 90 degrees
   apart, for the divider's sampled clock inputs.
   Assumes half_in changes only while the divider is held in reset. */
module pmd_clk_src (
    input wire logic mclk_in,       // sampling clock
    input wire logic [1:0] half_in, // cycles per quarter period, 1..3
    output logic [3:0] clk_out      // primary, then companions b, c, d
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] ph = 4'h0;
    int q;
    // Phases of two cycles or more keep every level visible to sampling
    always @(posedge mclk_in) begin
        ph <= (ph >= 4 * half_in - 1) ? 4'h0 : ph + 4'h1;
    end
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            q = (ph + k * half_in) % (4 * half_in);
            clk_out[k] = (q < 2 * half_in);
        end
    end
endmodule

// file: sim/pmd_divider_chk.sv
/* Port checker for the phase-matched divider.
   Assumes a bind to every divider instance with its own parameters. */
module pmd_divider_chk #(
    parameter DELAY_STAGES = 2,
    parameter [0:0] RELEASE_GATE_ENABLE = 1'h0
) (
    input wire mclk_in,                 // sampling clock
    input wire rst_in,                  // reset
    input wire primary_clock_in,        // primary clock
    input wire companion_clock_in_b,    // companion b
    input wire companion_clock_in_c,    // companion c
    input wire companion_clock_in_d,    // companion d
    input wire release_strobe_in,       // release strobe
    input wire primary_delayed_out,     // delayed primary
    input wire half_rate_out,           // primary / 2
    input wire quarter_rate_out,        // primary / 4
    input wire eighth_rate_out,         // primary / 8
    input wire companion_delayed_out_b, // delayed b
    input wire companion_delayed_out_c, // delayed c
    input wire companion_delayed_out_d  // delayed d
);
    timeunit 1ns;
    timeprecision 1ns;
    reg rel_seen = 1'b0;
    reg strobe_q = 1'b0;
    wire any_out = primary_delayed_out | half_rate_out | quarter_rate_out |
        eighth_rate_out | companion_delayed_out_b |
        companion_delayed_out_c | companion_delayed_out_d;
    always @(posedge mclk_in) begin
        rel_seen <= !rst_in && (rel_seen || (release_strobe_in && !strobe_q));
        strobe_q <= release_strobe_in;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence s_prim_rise;
        $rose(primary_delayed_out);
    endsequence
    sequence s_quiet3;
        !any_out [*3];
    endsequence
    AST_RST_LOW: assert property (
        disable iff (1'b0) rst_in |-> !any_out)
        else $error("output high during reset");
    AST_HALF_ALIGN: assert property (
        $changed(half_rate_out) |-> s_prim_rise)
        else $error("half rate moved off a primary rise");
    AST_QUARTER: assert property (
        $changed(quarter_rate_out) |-> $rose(half_rate_out))
        else $error("quarter rate moved off a half rise");
    AST_EIGHTH: assert property (
        $changed(eighth_rate_out) |-> $rose(quarter_rate_out))
        else $error("eighth rate moved off a quarter rise");
    AST_PRIM_DELAY: assert property (
        s_prim_rise |-> $past(primary_clock_in, DELAY_STAGES + 1))
        else $error("delayed primary rise without input rise");
    AST_COMP_B: assert property (
        $changed(companion_delayed_out_b) |->
        companion_delayed_out_b ==
        $past(companion_clock_in_b, DELAY_STAGES + 1))
        else $error("companion b not a delayed copy");
    AST_COMP_C: assert property (
        $changed(companion_delayed_out_c) |->
        companion_delayed_out_c ==
        $past(companion_clock_in_c, DELAY_STAGES + 1))
        else $error("companion c not a delayed copy");
    AST_COMP_D: assert property (
        $changed(companion_delayed_out_d) |->
        companion_delayed_out_d ==
        $past(companion_clock_in_d, DELAY_STAGES + 1))
        else $error("companion d not a delayed copy");
    AST_START: assert property ($fell(rst_in) |-> s_quiet3)
        else $error("output toggled before reset removal registered");
    AST_GATE: assert property (
        RELEASE_GATE_ENABLE && !rel_seen |->
        !half_rate_out && !quarter_rate_out && !eighth_rate_out)
        else $error("divided output ran before release");
endmodule

// file: sim/pmd_divider_tb.sv
/* Self-checking bench: a free-running divider and a release-gated one
   share four source clocks; edge counts are compared with ratios.
   Assumes the checker file is compiled before this one. */
module pmd_divider_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic strobe = 1'b1;
    logic [1:0] half = 2'h1;
    logic [13:0] prev = 14'h0000;
    logic [31:0] lfsr = 32'hEFFA;
    wire [3:0] clk;
    wire [13:0] outs;
    int cnt [14];
    int miscompares = 0;
    int checks = 0;
    initial forever #10 mclk_in = ~mclk_in;
    pmd_clk_src src_u (.mclk_in(mclk_in), .half_in(half), .clk_out(clk));
    pmd_divider dut_u (.mclk_in(mclk_in), .rst_in(rst_in),
        .primary_clock_in(clk[0]), .companion_clock_in_b(clk[1]),
        .companion_clock_in_c(clk[2]), .companion_clock_in_d(clk[3]),
        .release_strobe_in(strobe), .primary_delayed_out(outs[0]),
        .half_rate_out(outs[1]), .quarter_rate_out(outs[2]),
        .eighth_rate_out(outs[3]), .companion_delayed_out_b(outs[8]),
        .companion_delayed_out_c(outs[9]),
        .companion_delayed_out_d(outs[10]));
    pmd_divider #(.DELAY_STAGES(3), .RESET_RELEASE_SEL(2'h1),
        .RELEASE_GATE_ENABLE(1'h1)) dut_gate_u (.mclk_in(mclk_in),
        .rst_in(rst_in), .primary_clock_in(clk[0]),
        .companion_clock_in_b(clk[1]), .companion_clock_in_c(clk[2]),
        .companion_clock_in_d(clk[3]), .release_strobe_in(strobe),
        .primary_delayed_out(outs[4]), .half_rate_out(outs[5]),
        .quarter_rate_out(outs[6]), .eighth_rate_out(outs[7]),
        .companion_delayed_out_b(outs[11]),
        .companion_delayed_out_c(outs[12]),
        .companion_delayed_out_d(outs[13]));
    // Counted mid-cycle, clear of the edge that moves the outputs
    always @(negedge mclk_in) begin
        for (int i = 0; i < 14; i++) begin
            if (outs[i] === 1'b1 && prev[i] !== 1'b1) cnt[i]++;
        end
        prev = outs;
    end
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Divided rises coincide with the first primary rise, hence the round-up
    function automatic int exp_cnt(input int p, input int d);
        return (p + d - 1) / d;
    endfunction
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic div_chk(input int b);
        int c;
        c = 8 + 3 * (b / 4);
        chk("half", exp_cnt(cnt[b], 2), cnt[b + 1]);
        chk("quarter", exp_cnt(cnt[b], 4), cnt[b + 2]);
        chk("eighth", exp_cnt(cnt[b], 8), cnt[b + 3]);
        // Same period as the primary: rise counts differ by one at most
        for (int k = 0; k < 3; k++) begin
            chk("companion", 1, (cnt[c+k] - cnt[b]) inside {[-1:1]});
        end
    endtask
    initial begin
        cyc(8);
        for (int ep = 0; ep < 3; ep++) begin
            rst_in = 1'b1;
            #1 chk("outputs in reset", 32'h0, {18'h0, outs});
            lfsr = nxt(lfsr);
            half = 2'(lfsr[1:0] % 2'h3) + 2'h1;
            strobe = 1'b1;
            cyc(8);
            rst_in = 1'b0;
            cnt = '{default: 0};
            cyc(60 + int'(lfsr[3:0]));
            div_chk(0);
            chk("gated divided", 0, cnt[5] + cnt[6] + cnt[7]);
            chk("gated delayed runs", 1, cnt[4] > 0);
            strobe = 1'b0;
            cyc(2);
            for (int i = 0; i < 40 && outs[4] !== 1'b1; i++) cyc(1);
            if (outs[4] !== 1'b1) begin
                chk("gated primary running", 1, outs[4]);
                break;
            end
            strobe = 1'b1;
            cyc(1);
            cnt = '{default: 0};
            for (int i = 0; i < 80; i++) begin
                lfsr = nxt(lfsr);
                strobe = lfsr[0];
                cyc(1);
            end
            div_chk(4);
        end
        final_report();
    end
endmodule
bind pmd_divider pmd_divider_chk #(.DELAY_STAGES(DELAY_STAGES),
    .RELEASE_GATE_ENABLE(RELEASE_GATE_ENABLE)) chk_u (.*);
